// ---- mot_pkg.sv ----
// Package for the modulo overflow timer: register map, fields, reset values.
// Assumes an AXI4-Lite master with 32-bit data; registers sit in the low byte.
package mot_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [3:0] REG_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] REG_CLOCK_CONFIG   = 4'h4;
	localparam logic [3:0] REG_COUNT_VALUE    = 4'h8;
	localparam logic [3:0] REG_MODULO_LIMIT   = 4'hc;
	localparam int         ADDR_W             = 4;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int BIT_OVF   = 7;
	localparam int BIT_IRQEN = 6;
	localparam int BIT_CLR   = 5;
	localparam int BIT_HALT  = 4;
	localparam int CSS_LO    = 4;
	localparam int PSS_LO    = 0;

	// ************************************************************
	// Encodings and reset values
	// ************************************************************
	localparam logic [1:0] CSS_BUS   = 2'h0;
	localparam logic [1:0] CSS_FIXED = 2'h1;
	localparam logic [1:0] CSS_FALL  = 2'h2;
	localparam logic [1:0] CSS_RISE  = 2'h3;
	localparam logic [3:0] PSS_MAX   = 4'h8;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] RST_MOD   = 8'h00;
	localparam logic [1:0] RST_CSS   = 2'h0;
	localparam logic [3:0] RST_PSS   = 4'h0;
	localparam logic [1:0] AXI_OKAY  = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// Power and debug state of the host processor
	typedef struct packed {
		logic wait_mode;
		logic halt_level_one;
		logic halt_level_two;
		logic halt_level_three;
		logic halt_wake_reset;
		logic debug_active;
	} mot_power_t;

endpackage

// ---- mot_timer.sv ----
// Modulo overflow timer with AXI4-Lite register slave.
// Assumes external clock pin is slower than a quarter of clock_in and that
// the power controller pulses halt_wake_reset when level one or two ends.
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps

// Function
// - Eight-bit up-counter, free-running or limited by the modulo value.
// - Software-enabled overflow interrupt gives periodic interrupts on each wrap.
// - Source select 11 or 10 picks the external timer clock pin.
// - Sources: bus clock, fixed clock, external pin rising, external pin falling.
// - Prescaler divides by 1, 2, 4, 8, 16, 32, 64, 128, 256.
// - Timer keeps counting in wait mode; its interrupt can wake processor.
// - Timer disabled in every halt level and never wakes from halt.
// - Waking from halt level one or two returns timer to reset.
// - Level three ends by reset: reset state; by interrupt: state kept.
// - Active background debug suspends counting and holds the count.
// - After debug count resumes unless clear or modulo write reset it.
// - External pin is synchronised to the bus clock before use.
// - Four eight-bit registers: status/control, clock config, count, modulo.
// - Status: flag bit 7, enable 6, clear 5 write-only, halt 4.
// - Clock config: bits 7:6 zero, source 5:4, prescale 3:0.
// - Count register reads the full count and ignores writes.
// - Modulo register is a full eight-bit read/write limit.
// - Flag sets on wrap; cleared by read-then-write-0, clear or modulo write.
// - Interrupt request when enable and flag are both set; reset clears enable.
// - Writing 1 to clear zeros count and flag; reads return 0.
// - Halt freezes count, clearing resumes; reset sets halt.
module mot_timer (
	// Clock and reset
	input  wire logic               clock_in,
	input  wire logic               rst_b_in,
	// Clock sources
	input  wire logic               fixed_freq_clock_in,
	input  wire logic               ext_timer_clock_pin_in,
	// Processor power and debug state
	input  wire mot_pkg::mot_power_t power_in,
	// Interrupt request
	output logic                    irq_out,
	// AXI4-Lite write address
	input  wire logic [31:0]        s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0]        s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready
);

	// ************************************************************
	// State
	// ************************************************************
	// Only the low address bits select a register; the rest must be zero
	localparam int ADDR_W_L = mot_pkg::ADDR_W;

	logic [7:0]  count_q, count_d;
	logic [7:0]  mod_q, mod_d;
	logic [7:0]  presc_q, presc_d;
	logic [1:0]  css_q, css_d;
	logic [3:0]  pss_q, pss_d;
	logic        ovf_q, ovf_d;
	logic        irqen_q, irqen_d;
	logic        halt_q, halt_d;
	logic        ovf_seen_q, ovf_seen_d;
	logic [2:0]  pin_sync_q, pin_sync_d;
	logic [2:0]  fix_sync_q, fix_sync_d;
	logic [ADDR_W_L-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic        wbyte0_q, wbyte0_d;
	logic        aw_full_q, aw_full_d;
	logic        w_full_q, w_full_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;
	logic        awbad_q, awbad_d;

	// ************************************************************
	// Source edges and prescaler
	// ************************************************************
	logic src_tick;
	logic pre_tick;
	logic run;
	logic do_write;
	logic do_read;
	logic wr_sc, wr_clk, wr_mod;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] rd_byte;
	logic [7:0] next_count;
	logic [7:0] presc_mask;
	logic [3:0] pss_eff;
	logic       wrap;

	always_comb begin
		// Bit 0 of each synchroniser feeds only bit 1
		pin_sync_d = {pin_sync_q[1:0], ext_timer_clock_pin_in};
		fix_sync_d = {fix_sync_q[1:0], fixed_freq_clock_in};
		case (css_q)
			mot_pkg::CSS_BUS:   src_tick = 1'b1;
			mot_pkg::CSS_FIXED: src_tick = fix_sync_q[1] & ~fix_sync_q[2];
			mot_pkg::CSS_FALL:  src_tick = ~pin_sync_q[1] & pin_sync_q[2];
			mot_pkg::CSS_RISE:  src_tick = pin_sync_q[1] & ~pin_sync_q[2];
			default:            src_tick = 1'b1;
		endcase
	end

	// ************************************************************
	// Count control
	// ************************************************************
	always_comb begin
		// Larger prescale codes saturate at divide by 256
		pss_eff    = (pss_q > mot_pkg::PSS_MAX) ? mot_pkg::PSS_MAX : pss_q;
		// Low prescaler bits all ones marks the last source tick of a period
		presc_mask = 8'((9'h001 << pss_eff) - 9'h001);
		// Counting stops under halt bit, any halt level and debug
		// Wait mode is left out on purpose: the timer runs on and may wake the core
		run = ~halt_q & ~power_in.halt_level_one & ~power_in.halt_level_two
		    & ~power_in.halt_level_three & ~power_in.debug_active;
		pre_tick = run & src_tick & ((presc_q & presc_mask) == presc_mask);
		// Modulo zero must not match a zero count, or the count would never leave zero
		wrap = ((count_q == mod_q) && (mod_q != '0)) || (count_q == 8'hff);
		next_count = wrap ? mot_pkg::RST_COUNT : 8'(count_q + 8'h01);
	end

	// ************************************************************
	// Register bus decode
	// ************************************************************
	always_comb begin
		aw_full_d = aw_full_q;
		w_full_d  = w_full_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wbyte0_d  = wbyte0_q;
		awbad_d   = awbad_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_d = 1'b1;
			awaddr_d  = s_axi_awaddr[ADDR_W_L-1:0];
			// Upper bits are kept as one flag so they cannot alias a register
			awbad_d   = (s_axi_awaddr[31:ADDR_W_L] != '0);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wbyte0_d = s_axi_wstrb[0];
		end
		do_write = aw_full_q & w_full_q & ~bvalid_q;
		if (do_write) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
		end
		wr_hit = ~awbad_q
		       & ((awaddr_q == mot_pkg::REG_STATUS_CONTROL) || (awaddr_q == mot_pkg::REG_CLOCK_CONFIG)
		       || (awaddr_q == mot_pkg::REG_COUNT_VALUE) || (awaddr_q == mot_pkg::REG_MODULO_LIMIT));
		wr_sc  = do_write & wbyte0_q & wr_hit & (awaddr_q == mot_pkg::REG_STATUS_CONTROL);
		wr_clk = do_write & wbyte0_q & wr_hit & (awaddr_q == mot_pkg::REG_CLOCK_CONFIG);
		wr_mod = do_write & wbyte0_q & wr_hit & (awaddr_q == mot_pkg::REG_MODULO_LIMIT);
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (do_write) begin
			bvalid_d = 1'b1;
			bresp_d  = wr_hit ? mot_pkg::AXI_OKAY : mot_pkg::AXI_SLVERR;
		end

		do_read = s_axi_arvalid & s_axi_arready;
		rd_hit  = 1'b1;
		case (s_axi_araddr[ADDR_W_L-1:0])
			mot_pkg::REG_STATUS_CONTROL: rd_byte = {ovf_q, irqen_q, 1'b0, halt_q, 4'h0};
			mot_pkg::REG_CLOCK_CONFIG:   rd_byte = {2'h0, css_q, pss_q};
			mot_pkg::REG_COUNT_VALUE:    rd_byte = count_q;
			mot_pkg::REG_MODULO_LIMIT:   rd_byte = mod_q;
			default: begin
				rd_byte = 8'h00;
				rd_hit  = 1'b0;
			end
		endcase
		if (s_axi_araddr[31:ADDR_W_L] != '0) begin
			rd_byte = 8'h00;
			rd_hit  = 1'b0;
		end
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (do_read) begin
			rvalid_d = 1'b1;
			rdata_d  = {24'h000000, rd_byte};
			rresp_d  = rd_hit ? mot_pkg::AXI_OKAY : mot_pkg::AXI_SLVERR;
		end
	end

	assign s_axi_awready = ~aw_full_q;
	assign s_axi_wready  = ~w_full_q;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	// ************************************************************
	// Timer state
	// ************************************************************
	always_comb begin
		count_d    = count_q;
		presc_d    = presc_q;
		mod_d      = mod_q;
		css_d      = css_q;
		pss_d      = pss_q;
		ovf_d      = ovf_q;
		irqen_d    = irqen_q;
		halt_d     = halt_q;
		ovf_seen_d = ovf_seen_q;
		// Flag read while set arms the clear
		if (do_read && rd_hit && s_axi_araddr[ADDR_W_L-1:0] == mot_pkg::REG_STATUS_CONTROL && ovf_q) begin
			ovf_seen_d = 1'b1;
		end
		if (run && src_tick) begin
			presc_d = 8'(presc_q + 8'h01);
		end
		if (pre_tick) begin
			count_d = next_count;
		end
		if (wr_sc) begin
			irqen_d = wdata_q[mot_pkg::BIT_IRQEN];
			halt_d  = wdata_q[mot_pkg::BIT_HALT];
			if (!wdata_q[mot_pkg::BIT_OVF] && ovf_seen_q) begin
				ovf_d      = 1'b0;
				ovf_seen_d = 1'b0;
			end
			if (wdata_q[mot_pkg::BIT_CLR]) begin
				count_d = mot_pkg::RST_COUNT;
				presc_d = 8'h00;
				ovf_d   = 1'b0;
			end
		end
		if (wr_clk) begin
			// Count is kept across source and prescale changes
			css_d = wdata_q[mot_pkg::CSS_LO+1:mot_pkg::CSS_LO];
			pss_d = wdata_q[mot_pkg::PSS_LO+3:mot_pkg::PSS_LO];
		end
		if (wr_mod) begin
			mod_d   = wdata_q[7:0];
			count_d = mot_pkg::RST_COUNT;
			presc_d = 8'h00;
			ovf_d   = 1'b0;
		end
		// Hardware set wins over any clear in the same cycle
		if (pre_tick && wrap) begin
			ovf_d = 1'b1;
		end
	end

	// ************************************************************
	// Interrupt
	// ************************************************************
	// Level output; it stays high until software clears the flag or the enable, or a wake pulse resets the timer
	assign irq_out = irqen_q & ovf_q;

	// ************************************************************
	// Synchronisers
	// ************************************************************
	// Reset to the idle pin level so no false edge follows reset
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			pin_sync_q <= 3'h0;
			fix_sync_q <= 3'h0;
		end else begin
			pin_sync_q <= pin_sync_d;
			fix_sync_q <= fix_sync_d;
		end
	end

	// ************************************************************
	// Bus registers
	// ************************************************************
	// Bus state survives a halt wake so a pending response is not lost
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			aw_full_q  <= 1'b0;
			w_full_q   <= 1'b0;
			awaddr_q   <= '0;
			awbad_q    <= 1'b0;
			wdata_q    <= 32'h00000000;
			wbyte0_q   <= 1'b0;
			bvalid_q   <= 1'b0;
			bresp_q    <= mot_pkg::AXI_OKAY;
			rvalid_q   <= 1'b0;
			rdata_q    <= 32'h00000000;
			rresp_q    <= mot_pkg::AXI_OKAY;
		end else begin
			aw_full_q  <= aw_full_d;
			w_full_q   <= w_full_d;
			awaddr_q   <= awaddr_d;
			awbad_q    <= awbad_d;
			wdata_q    <= wdata_d;
			wbyte0_q   <= wbyte0_d;
			bvalid_q   <= bvalid_d;
			bresp_q    <= bresp_d;
			rvalid_q   <= rvalid_d;
			rdata_q    <= rdata_d;
			rresp_q    <= rresp_d;
		end
	end

	// ************************************************************
	// Timer registers
	// ************************************************************
	// The wake pulse is synchronous and touches only timer state
	always_ff @(posedge clock_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count_q    <= mot_pkg::RST_COUNT;
			presc_q    <= 8'h00;
			mod_q      <= mot_pkg::RST_MOD;
			css_q      <= mot_pkg::RST_CSS;
			pss_q      <= mot_pkg::RST_PSS;
			ovf_q      <= 1'b0;
			irqen_q    <= 1'b0;
			halt_q     <= 1'b1;
			ovf_seen_q <= 1'b0;
		end else if (power_in.halt_wake_reset) begin
			// Wake from deep halt levels restores reset state
			count_q    <= mot_pkg::RST_COUNT;
			presc_q    <= 8'h00;
			mod_q      <= mot_pkg::RST_MOD;
			css_q      <= mot_pkg::RST_CSS;
			pss_q      <= mot_pkg::RST_PSS;
			ovf_q      <= 1'b0;
			irqen_q    <= 1'b0;
			halt_q     <= 1'b1;
			ovf_seen_q <= 1'b0;
		end else begin
			count_q    <= count_d;
			presc_q    <= presc_d;
			mod_q      <= mod_d;
			css_q      <= css_d;
			pss_q      <= pss_d;
			ovf_q      <= ovf_d;
			irqen_q    <= irqen_d;
			halt_q     <= halt_d;
			ovf_seen_q <= ovf_seen_d;
		end
	end

endmodule

// ---- mot_ext_clock_model.sv ----
// Model of the external source driving the timer clock pin.
// Assumes the bench raises run_in for a burst and drops it between bursts.
`timescale 1ns/100ps
module mot_ext_clock_model (
	// Control
	input  wire logic run_in,
	// Pin
	output logic      pin_out
);
	// Half period of 3.7 bus cycles stays under a quarter of the bus rate
	always begin
		if (run_in) begin
			#370 pin_out = ~pin_out;
		end else begin
			pin_out = 1'b0;
			@(run_in);
		end
	end
endmodule

// ---- mot_timer_props.sv ----
// Checker for the bus and interrupt pins of the modulo overflow timer.
// Assumes it is bound to mot_timer and sees only its ports.
`timescale 1ns/100ps
module mot_timer_props (
	input wire logic                clock_in,
	input wire logic                rst_b_in,
	input wire mot_pkg::mot_power_t power_in,
	input wire logic                irq_out,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [31:0]         s_axi_rdata,
	input wire logic [1:0]          s_axi_rresp,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_b_in);
	wr_resp_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid) else $error("write response late");
	rd_resp_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	ar_blocked_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken too early");
	rd_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	irq_reset_a: assert property ($rose(rst_b_in) |-> !irq_out) else $error("interrupt after reset");
	irq_fall_cause_a: assert property ($fell(irq_out) |-> s_axi_bvalid || $past(power_in.halt_wake_reset))
		else $error("interrupt dropped without cause");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rresp == mot_pkg::AXI_SLVERR);
	cover property ($rose(irq_out));
endmodule

bind mot_timer mot_timer_props chk (.clock_in, .rst_b_in, .power_in, .irq_out, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ---- tb_mot_timer.sv ----
// Self-checking bench for the modulo overflow timer.
// Assumes mot_timer, its checker and the external clock model.
`timescale 1ns/100ps
module tb_mot_timer;
	logic                clock_in, rst_b_in, ffc, prun, pin, awv, wv, bry, arv, rry, awr, wr, bv, arr, rvl, irq;
	logic [31:0]         aa, wd, ra, rd, rv, x;
	logic [1:0]          br, rr, rsp;
	int                  num_errors, n_compared;
	mot_pkg::mot_power_t pw;

	mot_timer uut (.clock_in(clock_in), .rst_b_in(rst_b_in), .fixed_freq_clock_in(ffc),
		.ext_timer_clock_pin_in(pin), .power_in(pw), .irq_out(irq), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ra), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rvl), .s_axi_rready(rry));
	mot_ext_clock_model far (.run_in(prun), .pin_out(pin));

	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	// Fixed clock runs free at a tenth of the bus rate
	initial begin
		ffc = 1'b0;
		forever #500 ffc = ~ffc;
	end

	// ************************************************************
	// Bus and compare helpers
	// ************************************************************
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wreg(input logic [31:0] a, input logic [7:0] d);
		logic pa, pd;
		pa = 1'b1;
		pd = 1'b1;
		@(posedge clock_in);
		aa <= a;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		while (pa || pd) begin
			@(posedge clock_in);
			if (pa && awr) begin
				pa = 1'b0;
				awv <= 1'b0;
			end
			if (pd && wr) begin
				pd = 1'b0;
				wv <= 1'b0;
			end
		end
		while (!bv) @(posedge clock_in);
		rsp = br;
		bry <= 1'b0;
	endtask
	task rreg(input logic [31:0] a);
		@(posedge clock_in);
		ra <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do @(posedge clock_in); while (!arr);
		arv <= 1'b0;
		while (!rvl) @(posedge clock_in);
		rv = rd;
		rsp = rr;
		rry <= 1'b0;
	endtask
	// Runs from a cleared count, then halts and reads the count back
	task run_for(input logic [7:0] cfg, input int n);
		wreg(32'h4, cfg);
		wreg(32'h0, 8'h20);
		repeat (n) @(posedge clock_in);
		wreg(32'h0, 8'h10);
		rreg(32'h8);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task t_regs;
		rreg(32'h0);
		chk(rv, 32'h10, "status reset");
		rreg(32'h10);
		chk(rsp, mot_pkg::AXI_SLVERR, "unmapped");
		wreg(32'h4, 8'hff);
		rreg(32'h4);
		chk(rv, 32'h3f, "clock config");
		wreg(32'hc, 8'ha5);
		rreg(32'hc);
		chk(rv, 32'ha5, "modulo");
		wreg(32'h8, 8'h55);
		chk(rsp, mot_pkg::AXI_OKAY, "count write response");
		rreg(32'h8);
		chk(rv, 32'h0, "count write");
		wreg(32'h0, 8'h70);
		rreg(32'h0);
		chk(rv, 32'h50, "status bits");
		// Upper address bits must not alias the status register
		wreg(32'h10, 8'h00);
		chk(rsp, mot_pkg::AXI_SLVERR, "unmapped write");
		rreg(32'h0);
		chk(rv, 32'h50, "status after unmapped write");
		$display("test registers done");
	endtask
	task t_wrap;
		wreg(32'h4, 8'h00);
		wreg(32'hc, 8'h20);
		wreg(32'h0, 8'h60);
		repeat (40) @(posedge clock_in);
		chk(irq, 1'b1, "irq on wrap");
		rreg(32'h0);
		chk(rv[7], 1'b1, "flag on wrap");
		wreg(32'h0, 8'h50);
		chk(irq, 1'b0, "irq cleared");
		rreg(32'h8);
		x = rv;
		chk(rv <= 32'h20, 1'b1, "count in modulo");
		repeat (10) @(posedge clock_in);
		rreg(32'h8);
		chk(rv, x, "halted count");
		$display("test wrap done");
	endtask
	task t_pre;
		// Modulo zero runs free, so counts near 40 never wrap
		wreg(32'hc, 8'h00);
		for (int k = 0; k < 10; k++) begin
			run_for(k > 8 ? 8'h0f : 8'(k), 40 << (k > 8 ? 8 : k));
			chk(rv >= 39 && rv <= 45, 1'b1, "prescaled count");
		end
		$display("test prescaler done");
	endtask
	task t_src;
		run_for(8'h10, 200);
		chk(rv >= 18 && rv <= 22, 1'b1, "fixed source");
		for (int s = 0; s < 2; s++) begin
			wreg(32'h4, s ? 8'h20 : 8'h30);
			wreg(32'h0, 8'h20);
			prun <= 1'b1;
			repeat (20) @(posedge pin);
			@(posedge clock_in);
			prun <= 1'b0;
			repeat (10) @(posedge clock_in);
			wreg(32'h0, 8'h10);
			rreg(32'h8);
			chk(rv >= 32'd19 && rv <= 32'd20, 1'b1, "pin source");
		end
		$display("test sources done");
	endtask
	task t_pwr;
		// Bus source, so only the power state decides whether it counts
		wreg(32'h4, 8'h00);
		for (int j = 0; j < 6; j++) begin
			wreg(32'h0, 8'h20);
			pw <= mot_pkg::mot_power_t'(6'h1 << j);
			repeat (3) @(posedge clock_in);
			rreg(32'h8);
			x = rv;
			repeat (20) @(posedge clock_in);
			rreg(32'h8);
			chk(rv == x, j != 5, "frozen count");
			pw <= '0;
			rreg(32'h8);
			chk(rv != x, j != 1, "resumed count");
		end
		pw <= 6'h10;
		@(posedge clock_in);
		pw <= 6'h12;
		@(posedge clock_in);
		pw <= 6'h00;
		rreg(32'h0);
		chk(rv, 32'h10, "status after wake");
		$display("test power done");
	endtask

	task print_verdict;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge clock_in);
		num_errors++;
		print_verdict;
	end
	initial begin
		{rst_b_in, prun, awv, wv, bry, arv, rry} = '0;
		{aa, wd, ra} = '0;
		pw = '0;
		repeat (6) @(posedge clock_in);
		rst_b_in <= 1'b1;
		t_regs;
		t_wrap;
		t_pre;
		t_src;
		t_pwr;
		print_verdict;
	end
endmodule
